// >>> verilog/uart_chan_pkg.sv
// Constants shared by the serial channel register block and its FIFOs.
// Assumes an 8-bit host bus with three address lines per channel.
package uart_chan_pkg;
    // ==========================================================
    // Register offsets
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_ISR = 3'h2;
    localparam logic [2:0] ADDR_LCR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    localparam logic [2:0] ADDR_MSR = 3'h6;
    localparam logic [2:0] ADDR_SCR = 3'h7;
    // ==========================================================
    // Field positions
    localparam int LCR_DLAB = 7;
    localparam int FCR_EN = 0;
    localparam int FCR_RX_CLR = 1;
    localparam int FCR_TX_CLR = 2;
    localparam int FCR_DMA = 3;
    localparam int FCR_TRIG_LO = 6;
    localparam int FCR_TRIG_HI = 7;
    localparam int IER_W = 4;
    localparam int IER_RXD = 0;
    localparam int IER_TXE = 1;
    localparam int IER_LSR = 2;
    localparam int IER_MSR = 3;
    localparam int MCR_W = 5;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OUT1 = 2;
    localparam int MCR_INTEN = 3;
    localparam int MCR_LOOP = 4;
    localparam int LSR_DR = 0;
    localparam int LSR_OE = 1;
    localparam int LSR_THRE = 5;
    localparam int LSR_TEMT = 6;
    localparam int LSR_FERR = 7;
    // ==========================================================
    // Interrupt source codes, low nibble of int_status
    localparam logic [3:0] ISR_NONE = 4'h1;
    localparam logic [3:0] ISR_LSR = 4'h6;
    localparam logic [3:0] ISR_TMO = 4'hc;
    localparam logic [3:0] ISR_RXD = 4'h4;
    localparam logic [3:0] ISR_TXE = 4'h2;
    localparam logic [3:0] ISR_MSR = 4'h0;
    // ==========================================================
    // Buffer shapes and receive trigger levels
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 5;
    localparam int BUF_DEPTH = 2;
    localparam int BUF_CNT_W = 2;
    localparam int TAG_W = 3;
    localparam int RX_W = 11;
    localparam logic [4:0] TRIG_1 = 5'h01;
    localparam logic [4:0] TRIG_4 = 5'h04;
    localparam logic [4:0] TRIG_8 = 5'h08;
    localparam logic [4:0] TRIG_14 = 5'h0e;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_IER = 4'h0;
    localparam logic [4:0] RST_MCR = 5'h00;
endpackage

// >>> verilog/uart_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a registered head.
// Assumes DEPTH is a power of two; i_clear empties it in one edge.
`timescale 1ns/1ns
module uart_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW = 5
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data,
    output logic [CW-1:0] o_count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] rd_next;
    logic push;
    logic pop;

    assign o_ready = (o_count != CW'(DEPTH));
    assign o_valid = (o_count != '0);
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign rd_next = pop ? rd_ptr + 1'b1 : rd_ptr;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || i_clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            o_count <= '0;
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            rd_ptr <= rd_next;
            o_count <= o_count + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (push)
            mem[wr_ptr] <= i_data;
    end

    // Head register; bypass covers a write into the slot about to be read
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n)
            o_data <= '0;
        else if (push && (wr_ptr == rd_next))
            o_data <= i_data;
        else
            o_data <= mem[rd_next];
    end
endmodule

// >>> verilog/uart_channel_register_map.sv
// Host register block of one serial channel: map, FIFOs, interrupts.
// Assumes synchronous host strobes and an external shifter/baud block.
// Functional notes
// - Each channel has its own registers, picked by chip select and offset.
// - Offset 0, divisor latch off: read receive byte, write transmit byte.
// - Offset 1, divisor latch off: interrupt enable register, read/write.
// - Offset 2: read interrupt status, write FIFO control.
// - Offset 3: line format control, reachable in any latch state.
// - Offset 4: modem control; bit 4 loopback, bit 3 interrupt pin gate.
// - Offset 5: line status, read only.
// - Offset 6: modem status, levels in 7..4, change flags in 3..0.
// - Offset 7: scratch byte with no side effects.
// - Four enable bits mask five sources (receive bit also gates timeout); unmasked ones show in status.
// - FIFO mode receive interrupt follows level at or above trigger.
// - Status code for receive trigger clears at once; the registered interrupt pin follows one cycle later.
// - Data-ready sets when a byte enters receive FIFO, clears when empty.
// - Receive and transmit status sit in separate line status bits.
// - Line status bit 1 flags a receive overrun.
// - Line status bits 2..4 carry errors of the byte at the head.
// - Line status bit 5 flags transmit holding empty.
// - Line status bit 6 only when transmit FIFO and shifter empty.
// - Line status bit 7 when any byte in receive FIFO has an error.
// - Status bit 0 low while anything pending, high when idle.
// - FIFO control bits 7..6 pick trigger 1, 4, 8 or 14.
// - Each source clears on its own register read or data write.
// - Status reports only the highest pending source, fixed order.
`timescale 1ns/1ns
module uart_channel_register_map (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic [uart_chan_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [uart_chan_pkg::DATA_W-1:0] i_wdata,
    output logic [uart_chan_pkg::DATA_W-1:0] o_rdata,
    output logic o_int,
    input wire logic i_rx_valid,
    output logic o_rx_ready,
    input wire logic [uart_chan_pkg::DATA_W-1:0] i_rx_data,
    input wire logic i_rx_parity_err,
    input wire logic i_rx_frame_err,
    input wire logic i_rx_break,
    input wire logic i_rx_timeout,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    output logic [uart_chan_pkg::DATA_W-1:0] o_tx_data,
    input wire logic i_tx_shift_empty,
    input wire logic i_cts_n,
    input wire logic i_dsr_n,
    input wire logic i_ri_n,
    input wire logic i_cd_n,
    output logic o_rts_n,
    output logic o_dtr_n,
    output logic o_spare_user_output_n,
    output logic o_int_output_gate_n,
    output logic o_loopback,
    output logic o_dma_mode,
    output logic [uart_chan_pkg::DATA_W-1:0] o_line_format,
    output logic [15:0] o_divisor
);
    import uart_chan_pkg::*;

    logic rd_n_q, wr_n_q, rd_go, wr_go, dlab;
    logic [IER_W-1:0] int_enable;
    logic [7:0] line_format_control, scratch, div_lo, div_hi;
    logic [MCR_W-1:0] modem_line_control;
    logic fifo_en, dma;
    logic [1:0] trig_sel;
    logic [4:0] trig;
    logic rx_clr, tx_clr, rx_pop, rx_push, rx_in_ok, msr_rd, lsr_rd;
    logic [RX_W-1:0] rx_head;
    logic [CNT_W-1:0] rx_count, err_cnt, txf_count;
    logic [BUF_CNT_W-1:0] buf_count;
    logic [TAG_W-1:0] head_tag;
    logic overrun, head_ack, tmo_pend, tx_pend, thr_empty, thr_empty_q;
    logic thr_wr, tx_push, txf_ready, txf_valid, buf_ready, isr_rd;
    logic [7:0] txf_data, lsr_val, isr_val;
    logic [3:0] ms_in, ms_q, delta, ms_ev, code;
    logic ms_live;
    logic p_lsr, p_tmo, p_rxd, p_txe, p_msr;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    // ==========================================================
    // Host strobes: one access per falling edge of a strobe
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            rd_n_q <= i_rd_n;
            wr_n_q <= i_wr_n;
        end
    end

    assign rd_go = !i_cs_n && !i_rd_n && rd_n_q;
    assign wr_go = !i_cs_n && !i_wr_n && wr_n_q;
    assign dlab = line_format_control[LCR_DLAB];
    assign thr_wr = wr_go && (i_addr == ADDR_DATA) && !dlab;
    assign rx_pop = rd_go && (i_addr == ADDR_DATA) && !dlab;
    assign isr_rd = rd_go && (i_addr == ADDR_ISR);
    assign lsr_rd = rd_go && (i_addr == ADDR_LSR);
    assign msr_rd = rd_go && (i_addr == ADDR_MSR);

    // ==========================================================
    // Configuration registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            int_enable <= RST_IER;
            line_format_control <= RST_BYTE;
            modem_line_control <= RST_MCR;
            scratch <= RST_BYTE;
            div_lo <= RST_BYTE;
            div_hi <= RST_BYTE;
            fifo_en <= 1'b0;
            dma <= 1'b0;
            trig_sel <= 2'h0;
        end else if (wr_go) begin
            unique case (i_addr)
                ADDR_DATA: if (dlab) div_lo <= i_wdata;
                ADDR_IER: begin
                    if (dlab)
                        div_hi <= i_wdata;
                    else
                        int_enable <= i_wdata[IER_W-1:0];
                end
                ADDR_ISR: begin
                    // Other fields take effect only with the enable bit set
                    fifo_en <= i_wdata[FCR_EN];
                    if (i_wdata[FCR_EN]) begin
                        trig_sel <= i_wdata[FCR_TRIG_HI:FCR_TRIG_LO];
                        dma <= i_wdata[FCR_DMA];
                    end
                end
                ADDR_LCR: line_format_control <= i_wdata;
                ADDR_MCR: modem_line_control <= i_wdata[MCR_W-1:0];
                ADDR_SCR: scratch <= i_wdata;
                default: ;
            endcase
        end
    end

    // Toggling the enable also flushes, so no byte changes mode midway
    assign rx_clr = wr_go && (i_addr == ADDR_ISR)
        && ((fifo_en != i_wdata[FCR_EN])
        || (i_wdata[FCR_EN] && i_wdata[FCR_RX_CLR]));
    assign tx_clr = wr_go && (i_addr == ADDR_ISR)
        && ((fifo_en != i_wdata[FCR_EN])
        || (i_wdata[FCR_EN] && i_wdata[FCR_TX_CLR]));

    always_comb begin
        trig = TRIG_1;
        if (fifo_en) begin
            unique case (trig_sel)
                2'h0: trig = TRIG_1;
                2'h1: trig = TRIG_4;
                2'h2: trig = TRIG_8;
                2'h3: trig = TRIG_14;
            endcase
        end
    end

    // ==========================================================
    // Receive path
    // Without FIFOs the holding position is the only slot
    assign rx_in_ok = fifo_en ? (rx_count != CNT_W'(FIFO_DEPTH))
        : (rx_count == '0);
    assign o_rx_ready = rx_in_ok;
    assign rx_push = i_rx_valid && rx_in_ok;

    uart_fifo #(.WIDTH(RX_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_rx_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_clear(rx_clr),
        .i_valid(rx_push),
        .o_ready(),
        .i_data({i_rx_break, i_rx_frame_err, i_rx_parity_err, i_rx_data}),
        .o_valid(),
        .i_ready(rx_pop),
        .o_data(rx_head),
        .o_count(rx_count)
    );

    assign head_tag = (rx_count != '0) ? rx_head[RX_W-1:DATA_W]
        : '0;

    // Source cannot stall a shifter: a refused byte is an overrun
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n)
            overrun <= 1'b0;
        else
            overrun <= (overrun && !lsr_rd)
                || (i_rx_valid && !rx_in_ok);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || rx_clr)
            err_cnt <= '0;
        else
            err_cnt <= err_cnt
                + CNT_W'(rx_push && (i_rx_break || i_rx_frame_err
                || i_rx_parity_err))
                - CNT_W'(rx_pop && (head_tag != '0));
    end

    // Head errors raise the line interrupt until line status is read
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || rx_pop)
            head_ack <= 1'b0;
        else if (lsr_rd)
            head_ack <= 1'b1;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n)
            tmo_pend <= 1'b0;
        else
            tmo_pend <= (tmo_pend && !rx_pop)
                || (i_rx_timeout && (rx_count != '0));
    end

    a_overrun_flag: assert property (
        i_rx_valid && !o_rx_ready |=> lsr_val[LSR_OE])
        else $error("overrun not flagged");
    a_data_ready: assert property (
        rx_push && !rx_clr |=> lsr_val[LSR_DR] [*2] or rx_pop)
        else $error("data ready missing after receive");
    a_fifo_err_bit: assert property (
        rx_push && i_rx_parity_err && !rx_clr |=> lsr_val[LSR_FERR])
        else $error("fifo error bit not set");

    // ==========================================================
    // Transmit path: FIFO, then a two-entry buffer toward the shifter
    assign txf_ready = (txf_count != CNT_W'(FIFO_DEPTH));
    assign thr_empty = (txf_count == '0) && (buf_count == '0);
    assign tx_push = thr_wr && (fifo_en ? txf_ready : thr_empty);

    uart_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_tx_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_clear(tx_clr),
        .i_valid(tx_push),
        .o_ready(),
        .i_data(i_wdata),
        .o_valid(txf_valid),
        .i_ready(buf_ready),
        .o_data(txf_data),
        .o_count(txf_count)
    );

    uart_fifo #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH), .CW(BUF_CNT_W)) u_tx_buf (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_clear(tx_clr),
        .i_valid(txf_valid),
        .o_ready(buf_ready),
        .i_data(txf_data),
        .o_valid(o_tx_valid),
        .i_ready(i_tx_ready),
        .o_data(o_tx_data),
        .o_count(buf_count)
    );

    // Set wins over clear; enabling while empty also raises it
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            thr_empty_q <= 1'b1;
            tx_pend <= 1'b0;
        end else begin
            thr_empty_q <= thr_empty;
            tx_pend <= (tx_pend && !thr_wr
                && !(isr_rd && code == ISR_TXE))
                || (thr_empty && !thr_empty_q)
                || (wr_go && i_addr == ADDR_IER && !dlab
                && i_wdata[IER_TXE] && !int_enable[IER_TXE] && thr_empty);
        end
    end

    a_temt_both: assert property (
        lsr_val[LSR_TEMT] |-> thr_empty && i_tx_shift_empty
            && !o_tx_valid)
        else $error("shifter-empty bit with data left");
    a_thr_clear: assert property (
        thr_wr && !thr_empty_q |=> !tx_pend)
        else $error("transmit interrupt survives data write");

    // ==========================================================
    // Modem status: loopback feeds back the control bits
    assign ms_in = modem_line_control[MCR_LOOP]
        ? {modem_line_control[MCR_INTEN], modem_line_control[MCR_OUT1], modem_line_control[MCR_DTR], modem_line_control[MCR_RTS]}
        : ~{i_cd_n, i_ri_n, i_dsr_n, i_cts_n};
    // Ring flags its trailing edge only; first cycle after reset is quiet
    assign ms_ev = ms_live ? {ms_in[3] ^ ms_q[3], ms_q[2] && !ms_in[2],
        ms_in[1] ^ ms_q[1], ms_in[0] ^ ms_q[0]} : 4'h0;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ms_q <= 4'h0;
            ms_live <= 1'b0;
            delta <= 4'h0;
        end else begin
            ms_q <= ms_in;
            ms_live <= 1'b1;
            delta <= (msr_rd ? 4'h0 : delta) | ms_ev;
        end
    end

    // ==========================================================
    // Interrupt sources, masking and priority
    assign p_lsr = int_enable[IER_LSR]
        && (overrun || (head_tag != '0 && !head_ack));
    assign p_tmo = int_enable[IER_RXD] && tmo_pend;
    assign p_rxd = int_enable[IER_RXD] && (rx_count >= trig);
    assign p_txe = int_enable[IER_TXE] && tx_pend;
    assign p_msr = int_enable[IER_MSR] && (delta != 4'h0);

    always_comb begin
        if (p_lsr)
            code = ISR_LSR;
        else if (p_tmo)
            code = ISR_TMO;
        else if (p_rxd)
            code = ISR_RXD;
        else if (p_txe)
            code = ISR_TXE;
        else if (p_msr)
            code = ISR_MSR;
        else
            code = ISR_NONE;
    end

    assign isr_val = {{2{fifo_en}}, 2'h0, code};
    assign lsr_val = {err_cnt != '0, thr_empty && i_tx_shift_empty,
        thr_empty, head_tag, overrun, rx_count != '0};

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n)
            o_int <= 1'b0;
        else
            o_int <= modem_line_control[MCR_INTEN] && (code != ISR_NONE);
    end

    a_int_gated: assert property (
        !modem_line_control[MCR_INTEN] |=> !o_int)
        else $error("interrupt pin active while gated off");
    a_idle_code: assert property (
        int_enable == RST_IER |-> isr_val[3:0] == ISR_NONE)
        else $error("pending code with all sources masked");
    a_trig_level: assert property (
        fifo_en && int_enable[IER_RXD] && !p_lsr && !p_tmo
            && rx_count >= trig |-> isr_val[3:0] == ISR_RXD)
        else $error("receive trigger not reported");
    a_line_first: assert property (
        p_lsr |-> isr_val[3:0] == ISR_LSR
            ##1 o_int == $past(modem_line_control[MCR_INTEN]))
        else $error("line status not top priority");

    // ==========================================================
    // Read data, captured on the strobe's first cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n)
            o_rdata <= RST_BYTE;
        else if (rd_go) begin
            unique case (i_addr)
                ADDR_DATA: o_rdata <= dlab ? div_lo
                    : rx_head[DATA_W-1:0];
                ADDR_IER: o_rdata <= dlab ? div_hi
                    : {4'h0, int_enable};
                ADDR_ISR: o_rdata <= isr_val;
                ADDR_LCR: o_rdata <= line_format_control;
                ADDR_MCR: o_rdata <= {3'h0, modem_line_control};
                ADDR_LSR: o_rdata <= lsr_val;
                ADDR_MSR: o_rdata <= {ms_in, delta};
                ADDR_SCR: o_rdata <= scratch;
            endcase
        end
    end

    a_divisor_read: assert property (
        rd_go && i_addr == ADDR_DATA && dlab
            |=> o_rdata == $past(div_lo))
        else $error("divisor low byte not returned");
    a_scratch_keep: assert property (
        wr_go && i_addr == ADDR_SCR ##2 rd_go && i_addr == ADDR_SCR
            |=> o_rdata == $past(i_wdata, 3))
        else $error("scratch byte lost");

    c_trigger: cover property (fifo_en && rx_count == TRIG_14 && p_rxd);
    c_overrun: cover property (i_rx_valid && !o_rx_ready);
    c_tx_ack: cover property (isr_rd && code == ISR_TXE);
    c_loop: cover property (modem_line_control[MCR_LOOP] && delta != 4'h0);

    // ==========================================================
    // Pin-facing controls; RTS and DTR outputs drop during loopback
    assign o_rts_n = !(modem_line_control[MCR_RTS] && !modem_line_control[MCR_LOOP]);
    assign o_dtr_n = !(modem_line_control[MCR_DTR] && !modem_line_control[MCR_LOOP]);
    assign o_spare_user_output_n = !modem_line_control[MCR_OUT1];
    assign o_int_output_gate_n = !modem_line_control[MCR_INTEN];
    assign o_loopback = modem_line_control[MCR_LOOP];
    assign o_dma_mode = dma;
    assign o_line_format = line_format_control;
    assign o_divisor = {div_hi, div_lo};
endmodule

// >>> tb/uart_line_model.sv
// Serial-side stand-in: receive byte source and a stalling shifter.
// Assumes the bench pulses i_push for one cycle for each received byte.
`timescale 1ns/1ns
module uart_line_model (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_push,
    input wire logic [7:0] i_byte,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic o_tx_shift_empty
);
    // ======
    // Receive source and transmit shifter
    logic [3:0] busy;
    logic take;
    assign take = i_tx_valid && o_tx_ready;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rx_valid <= 1'b0;
            o_rx_data <= 8'h00;
            o_tx_ready <= 1'b0;
            busy <= 4'h0;
        end else begin
            o_rx_valid <= i_push;
            // Scramble between bytes so a stale value never passes
            o_rx_data <= i_push ? i_byte : ~o_rx_data;
            // Random stalls; never ready while a byte is shifting
            o_tx_ready <= busy == 4'h0 && !take && $urandom % 3 != 0;
            if (take) begin
                busy <= 4'h7;
            end else if (busy != 4'h0) begin
                busy <= busy - 4'h1;
            end
        end
    end
    assign o_tx_shift_empty = busy == 4'h0;
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the channel register block.
// Assumes the line model stands on the serial side of the block.
`timescale 1ns/1ns
module tb_top;
    import uart_chan_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_cs_n = 1'b1;
    logic i_rd_n = 1'b1;
    logic i_wr_n = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00;
    logic push = 1'b0;
    logic [7:0] push_byte = 8'h00;
    logic [3:0] modem_n = 4'hf;
    logic [2:0] rx_err = 3'h0;
    logic [7:0] o_rdata, o_tx_data, rx_data, v;
    logic [15:0] o_divisor;
    logic o_int, o_loopback, rx_valid, o_tx_valid, i_tx_ready, shift_empty;
    logic [7:0] rx_q[$], tx_q[$];
    int trig[4] = '{1, 4, 8, 14};
    int errors = 0;
    int samples_checked = 0;
    initial begin
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    uart_channel_register_map uart_channel_register_map_i (
        .i_clk_sys, .i_rst_n, .i_cs_n, .i_addr, .i_rd_n, .i_wr_n,
        .i_wdata, .o_rdata, .o_int, .i_rx_valid(rx_valid),
        .o_rx_ready(), .i_rx_data(rx_data), .i_rx_parity_err(rx_err[0]),
        .i_rx_frame_err(rx_err[1]), .i_rx_break(rx_err[2]), .i_rx_timeout(1'b0),
        .o_tx_valid, .i_tx_ready, .o_tx_data,
        .i_tx_shift_empty(shift_empty), .i_cts_n(modem_n[0]),
        .i_dsr_n(modem_n[1]), .i_ri_n(modem_n[2]), .i_cd_n(modem_n[3]),
        .o_rts_n(), .o_dtr_n(), .o_spare_user_output_n(),
        .o_int_output_gate_n(), .o_loopback, .o_dma_mode(),
        .o_line_format(), .o_divisor
    );
    uart_line_model uart_line_model_i (
        .i_clk_sys, .i_rst_n, .i_push(push), .i_byte(push_byte),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready),
        .o_tx_shift_empty(shift_empty)
    );
    // ======
    // Checking, bus cycles and byte injection
    task automatic check(input string n, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        {i_cs_n, i_wr_n, i_addr, i_wdata} = {2'b00, a, d};
        @(negedge i_clk_sys);
        {i_cs_n, i_wr_n, i_addr, i_wdata} = {2'b11, ~a, ~d};
    endtask
    // Read data lands on the taken edge
    task automatic rdc(input logic [2:0] a, input logic [7:0] m, e,
                       input string n);
        @(negedge i_clk_sys);
        {i_cs_n, i_rd_n, i_addr} = {2'b00, a};
        @(negedge i_clk_sys);
        {i_cs_n, i_rd_n, i_addr} = {2'b11, ~a};
        @(negedge i_clk_sys);
        check(n, o_rdata & m, e);
    endtask
    task automatic send(input logic [7:0] b);
        @(negedge i_clk_sys);
        {push, push_byte} = {1'b1, b};
        rx_q.push_back(b);
        @(negedge i_clk_sys);
        {push, push_byte} = {1'b0, ~b};
        repeat (2) @(negedge i_clk_sys);
    endtask
    always @(posedge i_clk_sys) begin
        if (i_rst_n && o_tx_valid === 1'b1 && i_tx_ready) begin
            check("tx_data", o_tx_data, tx_q.size() ? tx_q.pop_front() :
                  ~o_tx_data);
        end
    end
    initial begin
        repeat (30000) @(posedge i_clk_sys);
        errors++;
        stop_test();
    end
    // ======
    // Scenarios
    initial begin
        void'($urandom(32'h5b7f2bd1));
        repeat (16) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        rdc(ADDR_ISR, 8'hff, 8'h01, "int_status");
        rdc(ADDR_LCR, 8'hff, 8'h00, "lcr_reset");
        wr(ADDR_LSR, 8'hff);
        rdc(ADDR_LSR, 8'hff, 8'h60, "line_state");
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(ADDR_LCR, v & 8'h7f);
            wr(ADDR_SCR, v);
            rdc(ADDR_SCR, 8'hff, v, "scratch");
            rdc(ADDR_LCR, 8'hff, v & 8'h7f, "lcr");
        end
        wr(ADDR_MCR, 8'h18);
        rdc(ADDR_MCR, 8'hff, 8'h18, "mcr");
        check("loopback", {7'h0, o_loopback}, 8'h01);
        wr(ADDR_MCR, 8'h08);
        wr(ADDR_LCR, 8'h83);
        wr(ADDR_DATA, v);
        wr(ADDR_IER, ~v);
        rdc(ADDR_DATA, 8'hff, v, "div_low");
        rdc(ADDR_IER, 8'hff, ~v, "div_high");
        check("div_out_hi", o_divisor[15:8], ~v);
        check("div_out_lo", o_divisor[7:0], v);
        wr(ADDR_LCR, 8'h03);
        rdc(ADDR_IER, 8'hff, 8'h00, "ier_kept");
        // Loopback entry and exit both flag a carrier input change
        rdc(ADDR_MSR, 8'hff, 8'h08, "msr_flush");
        modem_n[0] = 1'b0;
        rdc(ADDR_MSR, 8'h01, 8'h01, "delta_cts");
        rdc(ADDR_MSR, 8'h01, 8'h00, "delta_clear");
        wr(ADDR_ISR, 8'h07);
        send(8'($urandom));
        rdc(ADDR_ISR, 8'hff, 8'hc1, "masked");
        rdc(ADDR_LSR, 8'h01, 8'h01, "data_ready");
        wr(ADDR_IER, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_ISR, {2'(c), 6'h03});
            rx_q.delete();
            repeat (trig[c] - 1) send(8'($urandom));
            rdc(ADDR_ISR, 8'hff, 8'hc1, "below_trig");
            send(8'($urandom));
            rdc(ADDR_ISR, 8'hff, 8'hc4, "at_trig");
            check("int_pin", {7'h0, o_int}, 8'h01);
            rdc(ADDR_DATA, 8'hff, rx_q.pop_front(), "rx_hold");
            rdc(ADDR_ISR, 8'hff, 8'hc1, "isr_drop");
            check("int_drop", {7'h0, o_int}, 8'h00);
            while (rx_q.size() > 0) begin
                rdc(ADDR_DATA, 8'hff, rx_q.pop_front(), "rx_drain");
            end
            rdc(ADDR_LSR, 8'h01, 8'h00, "rx_empty");
        end
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            tx_q.push_back(v);
            wr(ADDR_DATA, v);
        end
        rdc(ADDR_LSR, 8'h60, 8'h00, "tx_busy");
        for (int k = 0; k < 2000 && !(tx_q.size() == 0 && shift_empty);
             k++) begin
            @(negedge i_clk_sys);
        end
        if (tx_q.size() != 0) begin
            errors++;
            stop_test();
        end
        rdc(ADDR_LSR, 8'h60, 8'h60, "tx_done");
        // Single-slot mode: second byte is refused, first has bad parity
        wr(ADDR_ISR, 8'h00);
        wr(ADDR_IER, 8'h05);
        rx_err = 3'h1;
        send(8'($urandom));
        rx_err = 3'h0;
        send(8'($urandom));
        rdc(ADDR_ISR, 8'hff, 8'h06, "line_first");
        rdc(ADDR_LSR, 8'h9f, 8'h87, "rx_errors");
        rdc(ADDR_LSR, 8'h9f, 8'h85, "overrun_clr");
        rdc(ADDR_ISR, 8'hff, 8'h04, "rx_ready");
        rdc(ADDR_DATA, 8'hff, rx_q.pop_front(), "err_byte");
        rdc(ADDR_LSR, 8'h9f, 8'h00, "err_gone");
        stop_test();
    end
endmodule
